// *** rtl/ppfc_consts.vh ***
`ifndef PPFC_CONSTS_VH
`define PPFC_CONSTS_VH

// Register byte addresses
`define PPFC_ADDR_FMT      8'h90
`define PPFC_ADDR_CTRL     8'h94
`define PPFC_ADDR_STAT     8'h98

// Format word fields
`define PPFC_BIT_SRC       15
`define PPFC_MODE_HI       11
`define PPFC_MODE_LO       8
`define PPFC_BIT_DATA8     3
`define PPFC_BIT_STOP1     2
`define PPFC_FMT_RESET     16'h0000

// Mode codes
`define PPFC_MODE_HOST0    4'h0
`define PPFC_MODE_HOST5    4'h5

// Control register bits
`define PPFC_CTRL_CHG      0
`define PPFC_CTRL_SCAN     1

// Standard format
`define PPFC_STD_DATA8     1'b0
`define PPFC_STD_STOP1     1'b0
`define PPFC_STD_PAR_EN    1'b1
`define PPFC_STD_PAR_ODD   1'b0
`define PPFC_BAUD_STD      32'd9600
`define PPFC_CLK_HZ        32'd50000000
`define PPFC_BAUD_DIV      (`PPFC_CLK_HZ / `PPFC_BAUD_STD)

`endif

// *** rtl/ppfc_sync3.v ***
`timescale 1ns/1ps
module ppfc_sync3 (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire d_i,
  output reg  q_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Level counts once second and third stage agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o  <= 1'b0;
    end else if (ce_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule // ppfc_sync3

// *** rtl/ppfc_port_cfg.v ***
// Function
// - Custom port settings apply only while DIP switch position 4 is ON.
// - Format word bit 15 picks standard (0) or custom (1); resets to 0.
// - Standard format: 1 start, 7 data, even parity, 2 stop, 9600 bps.
// - Mode field bits 8..11; codes 00 and 05 both mean host link; default 0.
// - Peripheral bus mode serves programming tools other than the handheld console.
// - Bit 3 selects 7 data bits (0) or 8 data bits (1); default 0.
// - Bit 2 selects 2 stop bits (0) or 1 stop bit (1); default 0.
// - Data and stop fields act only in host link with custom source.
// - Changes are read at next scan start; setup-change instruction may change them.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ppfc_consts.vh"
module ppfc_port_cfg (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        dip_sw4_i,
  input  wire        scan_start_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         port_data8_o,
  output reg         port_stop1_o,
  output reg         port_par_en_o,
  output reg         port_par_odd_o,
  output reg  [15:0] port_baud_div_o,
  output reg         port_host_link_o,
  output reg         port_bus_mode_o,
  output reg         port_custom_o,
  output wire        settings_changed_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function is_host_link;
    input [3:0] mode;
    begin
      is_host_link = (mode == `PPFC_MODE_HOST0) || (mode == `PPFC_MODE_HOST5);
    end
  endfunction

  function addr_hit;
    input [7:0] adr;
    input [7:0] base;
    begin
      addr_hit = (adr == base);
    end
  endfunction

  localparam [15:0] FMT_RST   = `PPFC_FMT_RESET;
  // Rate divider fits well within 16 bits, so the upper half is cut on purpose
  localparam [31:0] BAUD_FULL = `PPFC_BAUD_DIV;
  localparam [15:0] BAUD_DIV  = BAUD_FULL[15:0];

  // Only the low address byte is decoded; there are no aliases above it
  wire        sw4_s;
  wire [15:0] fmt_q;
  reg  [7:0]  fmt_lane_q [0:1];
  reg         chg_q;
  reg         pend_q;
  reg  [31:0] rd_d;
  wire [31:0] stat_word;
  reg         data8_d;
  reg         stop1_d;
  reg         host_link_d;
  reg         bus_mode_d;
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr       = req & wb_we_i;
  wire        hit_fmt  = addr_hit(wb_adr_i, `PPFC_ADDR_FMT);
  wire        hit_ctrl = addr_hit(wb_adr_i, `PPFC_ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Switch synchroniser
  // DIP switch is a pin from outside the clock domain
  // Three stages cost a few cycles before a switch flip is seen
  ppfc_sync3 u_sw4 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (dip_sw4_i),
    .q_o   (sw4_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status word: live view of the applied format and the synced switch
  assign stat_word[31:12] = 20'h00000;
  assign stat_word[11]    = port_bus_mode_o;
  assign stat_word[10]    = port_custom_o;
  assign stat_word[9]     = port_host_link_o;
  assign stat_word[8]     = sw4_s;
  assign stat_word[7]     = port_par_odd_o;
  assign stat_word[6]     = port_par_en_o;
  assign stat_word[5]     = port_stop1_o;
  assign stat_word[4]     = port_data8_o;
  assign stat_word[3:0]   = 4'h0;

  // Read mux: unmapped addresses read zero but are still acked
  always @* begin
    case (wb_adr_i)
      `PPFC_ADDR_FMT: begin
        rd_d = {16'h0000, fmt_q};
      end
      `PPFC_ADDR_CTRL: begin
        rd_d = {31'h00000000, chg_q};
      end
      `PPFC_ADDR_STAT: begin
        rd_d = stat_word;
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait-free ack per request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  // One flip-flop byte per write lane; lanes 2 and 3 are accepted and dropped
  integer lane;
  always @(posedge clk_i) begin
    if (rst_i) begin
      fmt_lane_q[0] <= FMT_RST[7:0];
      fmt_lane_q[1] <= FMT_RST[15:8];
    end else if (ce_i && wr && hit_fmt) begin
      for (lane = 0; lane < 2; lane = lane + 1) begin
        if (wb_sel_i[lane]) begin
          fmt_lane_q[lane] <= wb_dat_i[lane*8 +: 8];
        end
      end
    end
  end

  assign fmt_q = {fmt_lane_q[1], fmt_lane_q[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Settings-changed flag and scan-cycle pending
  wire ctrl_wr    = wr & hit_ctrl & wb_sel_i[0];
  wire set_chg    = ctrl_wr & wb_dat_i[`PPFC_CTRL_CHG];
  wire force_scan = ctrl_wr & wb_dat_i[`PPFC_CTRL_SCAN];
  // A software-forced scan lets the setup-change instruction act at once
  wire scan_now   = scan_start_i | force_scan;

  assign settings_changed_o = chg_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      chg_q  <= 1'b1;
      pend_q <= 1'b0;
    end else if (ce_i) begin
      // A new set wins over the clear done by reconfiguration
      if (set_chg) begin
        chg_q <= 1'b1;
      end else if (pend_q) begin
        chg_q <= 1'b0;
      end
      // Load once per flagged scan; a scan held high does not reload twice
      pend_q <= chg_q & scan_now & ~pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective format, loaded only when a reconfiguration is pending
  wire [3:0] mode   = fmt_q[`PPFC_MODE_HI:`PPFC_MODE_LO];
  wire       host   = is_host_link(mode);
  wire       custom = sw4_s & fmt_q[`PPFC_BIT_SRC];
  wire       use_fields = custom & host;

  // Next applied format; parity and rate stay standard here
  always @* begin
    // Without switch 4 the mode field is ignored and host link stays
    host_link_d = ~sw4_s | host;
    // Non-host-link codes treated as tool bus for non-console programmers
    bus_mode_d  = sw4_s & ~host;
    data8_d     = `PPFC_STD_DATA8;
    stop1_d     = `PPFC_STD_STOP1;
    if (use_fields) begin
      data8_d = fmt_q[`PPFC_BIT_DATA8];
      stop1_d = fmt_q[`PPFC_BIT_STOP1];
    end
  end

  // Outputs change only on a flagged scan, never in the middle of a frame
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_data8_o     <= `PPFC_STD_DATA8;
      port_stop1_o     <= `PPFC_STD_STOP1;
      port_par_en_o    <= `PPFC_STD_PAR_EN;
      port_par_odd_o   <= `PPFC_STD_PAR_ODD;
      port_baud_div_o  <= BAUD_DIV;
      port_host_link_o <= 1'b1;
      port_bus_mode_o  <= 1'b0;
      port_custom_o    <= 1'b0;
    end else if (ce_i && pend_q) begin
      port_custom_o    <= custom;
      port_host_link_o <= host_link_d;
      port_bus_mode_o  <= bus_mode_d;
      port_par_en_o    <= `PPFC_STD_PAR_EN;
      port_par_odd_o   <= `PPFC_STD_PAR_ODD;
      port_baud_div_o  <= BAUD_DIV;
      port_data8_o     <= data8_d;
      port_stop1_o     <= stop1_d;
    end
  end
endmodule // ppfc_port_cfg

// *** bench/ppfc_port_cfg_assertions.sv ***
`timescale 1ns/1ps
module ppfc_chk (
  input wire        clk_i, rst_i, scan_start_i, wb_ack_o, settings_changed_o,
  input wire        port_data8_o, port_stop1_o, port_par_en_o, port_par_odd_o,
  input wire        port_host_link_o, port_bus_mode_o, port_custom_o,
  input wire [15:0] port_baud_div_o,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i
);
  // Forced scan through the control register, seen while its ack stands
  logic frc_q;
  always @(posedge clk_i) frc_q <= wb_ack_o && wb_we_i && wb_adr_i == 8'h94 && wb_dat_i[1];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_std_fmt: assert property (!port_custom_o |-> !port_data8_o && !port_stop1_o)
    else $error("custom format leaked");
  a_par_even: assert property (port_par_en_o && !port_par_odd_o) else $error("parity");
  a_baud_std: assert property (port_baud_div_o == 16'h1458) else $error("baud");
  a_mode_excl: assert property (port_host_link_o ^ port_bus_mode_o) else $error("mode");
  a_custom_gate: assert property (port_data8_o || port_stop1_o |-> port_host_link_o && port_custom_o)
    else $error("field gating");
  a_cfg_hold: assert property ($changed({port_data8_o, port_stop1_o, port_bus_mode_o})
    |-> $past(settings_changed_o)) else $error("change without flag");
  a_flag_clr: assert property ($fell(settings_changed_o) |-> $past(scan_start_i, 2) || frc_q)
    else $error("flag cleared early");
  a_load_time: assert property (settings_changed_o && scan_start_i |-> ##2 !settings_changed_o)
    else $error("flag not cleared");
endmodule // ppfc_chk

// *** bench/ppfc_host.sv ***
`timescale 1ns/1ps
// Frame length the host must use to stay in step with the port
module ppfc_host (
  input  wire       data8_i, stop1_i, par_en_i,
  output wire [3:0] frame_bits_o
);
  assign frame_bits_o = 4'h8 + data8_i + par_en_i + (stop1_i ? 4'h1 : 4'h2);
endmodule // ppfc_host

// *** bench/tb_ppfc_port_cfg.sv ***
`timescale 1ns/1ps
module tb_ppfc_port_cfg;
  logic        clk_i = 0, rst_i = 1, sw = 0, scan = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, s = 32'h7E278141;
  wire  [31:0] rdat;
  wire  [15:0] div;
  wire  [3:0]  fb;
  logic [3:0]  e;
  wire         ack, d8, s1, pe, po, hl, bm, cu, chg;
  int          failures = 0, num_checks = 0, n = 0;
  always #10 clk_i = ~clk_i;
  ppfc_port_cfg uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .dip_sw4_i(sw),
    .scan_start_i(scan), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_data8_o(d8),
    .port_stop1_o(s1), .port_par_en_o(pe), .port_par_odd_o(po), .port_baud_div_o(div),
    .port_host_link_o(hl), .port_bus_mode_o(bm), .port_custom_o(cu), .settings_changed_o(chg));
  ppfc_host host (.data8_i(d8), .stop1_i(s1), .par_en_i(pe), .frame_bits_o(fb));
  task check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  task scanp;
    scan <= 1;
    @(posedge clk_i);
    scan <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  function logic [31:0] lf(input logic [31:0] v);
    lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected {bus, host, stop1, data8}
  function logic [3:0] expf(input logic sw4, input logic [15:0] w);
    logic h, c;
    h = !sw4 || w[11:8] == 4'h0 || w[11:8] == 4'h5;
    c = sw4 && w[15] && h;
    expf = {!h, h, c && w[2], c && w[3]};
  endfunction
  always @(posedge clk_i) if (++n == 20000) begin failures++; conclude; end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'h90, 32'h0); check("fmt reset", rd, 32'h0);
    wb(0, 8'hFC, 32'h0); check("unmapped", rd, 32'h0);
    scanp; check("std frame", fb, 32'hB);
    check("flag clear", chg, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      s = lf(s);
      // Corner cases first: switch on, custom source, both host link codes
      if (i < 4) begin s[16:15] = 2'b11; s[11:8] = i[0] ? 4'h5 : 4'h0; end
      sw <= s[16];
      repeat (6) @(posedge clk_i);
      wb(1, 8'h90, {16'h0, s[15:0]}); wb(0, 8'h90, 32'h0);
      check("fmt rw", rd, {16'h0, s[15:0]});
      wb(1, 8'h94, 32'h1); check("flag set", chg, 32'h1);
      // Odd rounds reload through the control register instead of a scan pulse
      if (i[0]) wb(1, 8'h94, 32'h2);
      else scanp;
      e = expf(s[16], s[15:0]);
      check("port cfg", {bm, hl, s1, d8}, e);
      check("custom", cu, s[16] & s[15]);
      check("par baud", {pe, po, div}, {2'b10, 16'h1458});
      wb(0, 8'h98, 32'h0);
      check("status", rd, {20'h0, e[3], s[16] & s[15], e[2], s[16], 2'b01, e[1], e[0], 4'h0});
      wb(0, 8'h94, 32'h0); check("flag rd", rd, 32'h0);
    end
    $display("random format test done");
    conclude;
  end
endmodule // tb_ppfc_port_cfg
bind ppfc_port_cfg ppfc_chk u_chk (.*);
